// [logic/bcrc_pkg.sv]
package bcrc_pkg;

    // Register offsets on the plain software port
    localparam logic [1:0] BCRC_OFF_INPUT   = 2'h0;
    localparam logic [1:0] BCRC_OFF_SUM_LOW = 2'h1;
    localparam logic [1:0] BCRC_OFF_SUM_HIGH = 2'h2;
    localparam logic [1:0] BCRC_OFF_CONTROL = 2'h3;

    localparam int unsigned BCRC_POLYNOMIAL_SELECT_SEL_BIT = 0;

    localparam logic [7:0]  BCRC_RST_BYTE    = 8'h00;
    localparam logic [15:0] BCRC_RST_SUM     = 16'h0000;
    localparam logic        BCRC_RST_SEL     = 1'b0;

    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CCITT  = 16'h1021;
    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CRC16  = 16'h8005;

    localparam int unsigned BCRC_STEPS       = 8;

    // Software read or write request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } bcrc_req_t;

endpackage : bcrc_pkg

// [logic/bcrc_top.sv]
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module bcrc_top
    import bcrc_pkg::*;
(
    input  wire logic       sys_clk,   // System clock, 100 MHz
    input  wire logic       rst,       // Synchronous reset, active high
    input  wire bcrc_req_t  req,       // Strobes, address and write data
    output logic [7:0]      rdata      // Read data, cycle after read strobe
);

    logic [7:0]  in_byte_q;
    logic [15:0] sum_q;
    logic        sel_q;
    logic [7:0]  rdata_q;

    function automatic logic [15:0] bcrc_step(input logic [15:0] t,
                                               input logic [15:0] polynomial_select);
        logic [15:0] shifted;
        shifted = {t[14:0], 1'b0};
        // The bit that leaves the top decides, not the new top bit
        return t[15] ? (shifted ^ polynomial_select) : shifted;
    endfunction : bcrc_step

    function automatic logic [15:0] bcrc_fold(input logic [15:0] sum,
                                               input logic [7:0]  din,
                                               input logic        sel);
        logic [15:0] t;
        logic [15:0] polynomial_select;
        t    = sum ^ {din, 8'h00};
        polynomial_select = sel ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT;
        for (int i = 0; i < BCRC_STEPS; i++) begin
            t = bcrc_step(t, polynomial_select);
        end
        return t;
    endfunction : bcrc_fold

    // One decode used by the input-byte write and most checks; the seed and control writes compare the address inline
    function automatic logic bcrc_hit(input logic       strobe,
                                      input logic [1:0] addr,
                                      input logic [1:0] off);
        return strobe && (addr == off);
    endfunction : bcrc_hit

    logic in_wr;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic rd_in;
    logic rd_low;
    logic rd_high;
    logic rd_ctrl;
    assign in_wr   = bcrc_hit(req.wr, req.addr, BCRC_OFF_INPUT);
    assign wr_low  = bcrc_hit(req.wr, req.addr, BCRC_OFF_SUM_LOW);
    assign wr_high = bcrc_hit(req.wr, req.addr, BCRC_OFF_SUM_HIGH);
    assign wr_ctrl = bcrc_hit(req.wr, req.addr, BCRC_OFF_CONTROL);
    assign rd_in   = bcrc_hit(req.rd, req.addr, BCRC_OFF_INPUT);
    assign rd_low  = bcrc_hit(req.rd, req.addr, BCRC_OFF_SUM_LOW);
    assign rd_high = bcrc_hit(req.rd, req.addr, BCRC_OFF_SUM_HIGH);
    assign rd_ctrl = bcrc_hit(req.rd, req.addr, BCRC_OFF_CONTROL);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_byte_q <= BCRC_RST_BYTE;
        end else if (in_wr) begin
            in_byte_q <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sum_q <= BCRC_RST_SUM;
        end else if (in_wr) begin
            sum_q <= bcrc_fold(sum_q, req.wdata, sel_q);
        end else if (req.wr && req.addr == BCRC_OFF_SUM_LOW) begin
            sum_q[7:0] <= req.wdata;
        end else if (req.wr && req.addr == BCRC_OFF_SUM_HIGH) begin
            sum_q[15:8] <= req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_q <= BCRC_RST_SEL;
        end else if (req.wr && req.addr == BCRC_OFF_CONTROL) begin
            sel_q <= req.wdata[BCRC_POLYNOMIAL_SELECT_SEL_BIT];
        end
    end

    // Read data holds only in the cycle after the strobe; zero otherwise
    always_ff @(posedge sys_clk) begin
        if (rst || !req.rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (req.addr)
                BCRC_OFF_INPUT:    rdata_q <= in_byte_q;
                BCRC_OFF_SUM_LOW:  rdata_q <= sum_q[7:0];
                BCRC_OFF_SUM_HIGH: rdata_q <= sum_q[15:8];
                BCRC_OFF_CONTROL:  rdata_q <= {7'h00, sel_q};
                default:           rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata = rdata_q;

    fold_update_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_wr |=> sum_q == bcrc_fold($past(sum_q), $past(req.wdata), $past(sel_q)))
        else $error("checksum not folded after input write");

    ccitt_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h01 && !sel_q)
            |=> sum_q == 16'h1021)
        else $error("ccitt constant wrong");

    crc16_one_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h02 && sel_q)
            |=> sum_q == 16'h800F)
        else $error("crc16 feedback wrong");

    seed_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        (req.wr && req.addr == BCRC_OFF_SUM_LOW)
            |=> sum_q == {$past(sum_q[15:8]), $past(req.wdata)})
        else $error("low seed write not direct");

    control_read_a: assert property (@(posedge sys_clk) disable iff (rst)
        (req.rd && req.addr == BCRC_OFF_CONTROL) |=> rdata[7:1] == 7'h00)
        else $error("control upper bits not zero");

    hold_sum_a: assert property (@(posedge sys_clk) disable iff (rst)
        !req.wr |=> $stable(sum_q))
        else $error("checksum changed without write");

    // Single bytes folded into a cleared checksum, CCITT
    ccitt_byte_00_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h00 && !sel_q)
            |=> sum_q == 16'h0000)
        else $error("ccitt entry 00 wrong");

    ccitt_byte_02_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h02 && !sel_q)
            |=> sum_q == 16'h2042)
        else $error("ccitt entry 02 wrong");

    ccitt_byte_03_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h03 && !sel_q)
            |=> sum_q == 16'h3063)
        else $error("ccitt entry 03 wrong");

    ccitt_byte_04_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h04 && !sel_q)
            |=> sum_q == 16'h4084)
        else $error("ccitt entry 04 wrong");

    ccitt_byte_05_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h05 && !sel_q)
            |=> sum_q == 16'h50A5)
        else $error("ccitt entry 05 wrong");

    ccitt_byte_06_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h06 && !sel_q)
            |=> sum_q == 16'h60C6)
        else $error("ccitt entry 06 wrong");

    ccitt_byte_07_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h07 && !sel_q)
            |=> sum_q == 16'h70E7)
        else $error("ccitt entry 07 wrong");

    // Single bytes folded into a cleared checksum, CRC-16
    crc16_byte_00_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h00 && sel_q)
            |=> sum_q == 16'h0000)
        else $error("crc16 entry 00 wrong");

    crc16_byte_01_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h01 && sel_q)
            |=> sum_q == 16'h8005)
        else $error("crc16 entry 01 wrong");

    crc16_byte_03_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h03 && sel_q)
            |=> sum_q == 16'h000A)
        else $error("crc16 entry 03 wrong");

    crc16_byte_04_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h04 && sel_q)
            |=> sum_q == 16'h801B)
        else $error("crc16 entry 04 wrong");

    crc16_byte_05_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h05 && sel_q)
            |=> sum_q == 16'h001E)
        else $error("crc16 entry 05 wrong");

    crc16_byte_06_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h06 && sel_q)
            |=> sum_q == 16'h0014)
        else $error("crc16 entry 06 wrong");

    crc16_byte_07_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h07 && sel_q)
            |=> sum_q == 16'h8011)
        else $error("crc16 entry 07 wrong");

    // A four-byte stream, each step starting from the previous result
    ccitt_seq_1_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h78 && !sel_q)
            |=> sum_q == 16'hFF9F)
        else $error("ccitt stream step 1 wrong");

    ccitt_seq_2_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'hFF9F && req.wdata == 8'h56 && !sel_q)
            |=> sum_q == 16'hBBC3)
        else $error("ccitt stream step 2 wrong");

    ccitt_seq_3_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'hBBC3 && req.wdata == 8'h34 && !sel_q)
            |=> sum_q == 16'hA367)
        else $error("ccitt stream step 3 wrong");

    ccitt_seq_4_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'hA367 && req.wdata == 8'h12 && !sel_q)
            |=> sum_q == 16'hD0FA)
        else $error("ccitt stream step 4 wrong");

    crc16_seq_1_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0000 && req.wdata == 8'h78 && sel_q)
            |=> sum_q == 16'h0110)
        else $error("crc16 stream step 1 wrong");

    crc16_seq_2_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h0110 && req.wdata == 8'h56 && sel_q)
            |=> sum_q == 16'h91F1)
        else $error("crc16 stream step 2 wrong");

    crc16_seq_3_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'h91F1 && req.wdata == 8'h34 && sel_q)
            |=> sum_q == 16'hF2DE)
        else $error("crc16 stream step 3 wrong");

    crc16_seq_4_a: assert property (@(posedge sys_clk) disable iff (rst)
        (in_wr && sum_q == 16'hF2DE && req.wdata == 8'h12 && sel_q)
            |=> sum_q == 16'h5C43)
        else $error("crc16 stream step 4 wrong");

    // Register file behaviour around the checksum
    seed_high_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_high
            |=> sum_q == {$past(req.wdata), $past(sum_q[7:0])})
        else $error("high seed write not direct");

    seed_no_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_low || wr_high)
            |=> $stable(in_byte_q))
        else $error("seed write disturbed input byte");

    input_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_wr
            |=> in_byte_q == $past(req.wdata))
        else $error("input byte not captured");

    input_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !in_wr
            |=> $stable(in_byte_q))
        else $error("input byte changed without write");

    select_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl
            |=> sel_q == $past(req.wdata[BCRC_POLYNOMIAL_SELECT_SEL_BIT]))
        else $error("select bit not written");

    select_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl
            |=> $stable(sel_q))
        else $error("select bit changed without write");

    ctrl_no_fold_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl
            |=> $stable(sum_q))
        else $error("control write changed checksum");

    ctrl_keep_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl
            |=> $stable(in_byte_q))
        else $error("control write changed input byte");

    read_no_fold_a: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd
            |=> $stable(sum_q))
        else $error("read changed checksum");

    read_keeps_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd
            |=> $stable(sel_q))
        else $error("read changed select bit");

    read_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_low
            |=> rdata == $past(sum_q[7:0]))
        else $error("checksum low byte read wrong");

    read_high_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_high
            |=> rdata == $past(sum_q[15:8]))
        else $error("checksum high byte read wrong");

    read_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_in
            |=> rdata == $past(in_byte_q))
        else $error("input byte read wrong");

    read_control_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ctrl
            |=> rdata == {7'h00, $past(sel_q)})
        else $error("control read wrong");

    read_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
        !req.rd
            |=> rdata == 8'h00)
        else $error("read data not zero when idle");

    reset_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst)
            |-> (sum_q == BCRC_RST_SUM && sel_q == BCRC_RST_SEL && in_byte_q == BCRC_RST_BYTE))
        else $error("registers not cleared by reset");

endmodule : bcrc_top

// [dv/bcrc_top_tb.sv]
`timescale 1ns/10ps
module bcrc_top_tb;
    import bcrc_pkg::*;
    logic        sys_clk = 1'b0; // System clock
    logic        rst     = 1'b1; // Reset
    bcrc_req_t   req     = '0;   // Software request
    logic [7:0]  rdata;          // Read data
    int          miscompares = 0;
    int          check_count = 0;
    logic [15:0] one_exp [2][8] = '{'{16'h0000, 16'h1021, 16'h2042, 16'h3063,
        16'h4084, 16'h50A5, 16'h60C6, 16'h70E7}, '{16'h0000, 16'h8005, 16'h800F,
        16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
    logic [15:0] seq_exp [2][4] = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
        '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
    logic [7:0]  seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    always #5 sys_clk = ~sys_clk;
    bcrc_top bcrc_top_inst (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1 d = rdata;
    endtask : rd
    task automatic sum(input logic [15:0] e);
        logic [7:0] h;
        logic [7:0] l;
        rd(BCRC_OFF_SUM_HIGH, h);
        rd(BCRC_OFF_SUM_LOW, l);
        chk("checksum", e, {h, l});
    endtask : sum
    initial begin
        logic [7:0] v;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0], v);
            chk("reset value", 16'h0000, {8'h00, v});
        end
        wr(BCRC_OFF_CONTROL, 8'hFE);
        rd(BCRC_OFF_CONTROL, v);
        chk("control", 16'h0000, {8'h00, v});
        @(posedge sys_clk);
        #1 chk("read idle", 16'h0000, {8'h00, rdata});
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            wr(BCRC_OFF_CONTROL, p[7:0]);
            for (int i = 0; i < 8; i++) begin
                wr(BCRC_OFF_SUM_LOW, 8'h00);
                wr(BCRC_OFF_SUM_HIGH, 8'h00);
                wr(BCRC_OFF_INPUT, i[7:0]);
                rd(BCRC_OFF_INPUT, v);
                chk("input byte", {8'h00, i[7:0]}, {8'h00, v});
                sum(one_exp[p][i]);
            end
            wr(BCRC_OFF_SUM_LOW, 8'h00);
            wr(BCRC_OFF_SUM_HIGH, 8'h00);
            for (int i = 0; i < 4; i++) begin
                wr(BCRC_OFF_INPUT, seq_in[i]);
                sum(seq_exp[p][i]);
            end
        end
        $display("test polynomials done");
        wr(BCRC_OFF_SUM_LOW, 8'h34);
        wr(BCRC_OFF_SUM_HIGH, 8'h12);
        sum(16'h1234);
        $display("test seed done");
        close_out();
    end
    // Whole run needs under 2000 cycles
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
endmodule : bcrc_top_tb
